// *** src/vcdac_pkg.sv ***
// package of constants for the voice coil actuator converter controller
package vcdac_pkg;
   localparam int          CODE_W        = 10;          // converter code width
   localparam logic [6:0]  SLAVE_ADDR    = 7'h18;       // seven-bit bus address
   localparam logic [9:0]  CODE_RST      = 10'h000;     // code after reset
   localparam logic [1:0]  SLEW_RST      = 2'h0;        // slew mode after reset
   localparam int          SYS_CLK_KHZ   = 50000;       // system clock rate
   localparam int          SCL_MAX_KHZ   = 400;         // fastest serial clock
   // cycles of system clock per serial clock period at the fastest rate (round down)
   localparam int          SCL_MIN_CYC   = SYS_CLK_KHZ / SCL_MAX_KHZ;
   localparam logic [3:0]  SLEW_STEP_LOG = 4'h2;        // log2 of base slew step spacing
   // slew modes: direct, then three ramps of decreasing speed
   typedef enum logic [1:0] {SLEW_DIRECT, SLEW_FAST, SLEW_MED, SLEW_SLOW} vcdac_slew_t;
endpackage

// *** src/vcdac_slew.sv ***
// output slew shaper that walks the drive code toward the target
`timescale 1ns/1ps
module vcdac_slew #(
   parameter int W = 10
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   // control
   input  wire logic [W-1:0] target,
   input  wire logic [1:0]   mode,
   input  wire logic         force_zero,
   // output
   output logic      [W-1:0] drive_code
);
   logic [W-1:0] code_q, code_d;     // present drive code
   logic [7:0]   tick_q, tick_d;     // step spacing counter
   logic [7:0]   span;               // cycles between steps

   // next drive code and step timing
   always_comb begin
      span   = 8'h00;
      code_d = code_q;
      tick_d = tick_q;
      case (mode)
         vcdac_pkg::SLEW_FAST: span = 8'h01 << vcdac_pkg::SLEW_STEP_LOG;          // 4 cycles a step
         vcdac_pkg::SLEW_MED:  span = 8'h01 << {vcdac_pkg::SLEW_STEP_LOG, 1'h0};  // 16 cycles a step
         vcdac_pkg::SLEW_SLOW: span = 8'h01 << (vcdac_pkg::SLEW_STEP_LOG * 4'h3); // 64 cycles a step
         default: span = 8'h00;
      endcase
      if (force_zero) begin // held at zero in shutdown or before first write
         code_d = '0;
         tick_d = 8'h00;
      end else if (span == 8'h00) begin // direct mode
         code_d = target;
      end else if (tick_q >= span - 8'h01) begin // take one step
         tick_d = 8'h00;
         if (code_q < target) begin
            code_d = code_q + {{(W-1){1'b0}}, 1'b1};
         end else if (code_q > target) begin
            code_d = code_q - {{(W-1){1'b0}}, 1'b1};
         end
      end else begin
         tick_d = tick_q + 8'h01;
      end
   end

   // register stage
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         code_q <= '0;
         tick_q <= 8'h00;
      end else begin
         code_q <= code_d;
         tick_q <= tick_d;
      end
   end

   assign drive_code = code_q;

   // assertions
   slew_unit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (mode != 2'h0 && !force_zero) |=> (code_q - $past(code_q) <= 1 || $past(code_q) - code_q <= 1))
      else $error("slew moved more than one step");
   slew_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      force_zero |=> code_q == '0)
      else $error("drive not zeroed");
endmodule // vcdac_slew

// *** src/vcdac_top.sv ***
// i2c slave and input register of the voice coil actuator converter
// Overview of operation
// - one ten-bit code sets sink current
// - output zero until first valid write
// - shutdown input, polarity chosen per variant
// - i2c write and read up to 400 kHz
// - completed read clears the input register
// - acknowledge only address 0x18
// - selectable slew modes shape code changes
`timescale 1ns/1ps
module vcdac_top #(
   parameter bit SHDN_ACTIVE_HIGH = 1'b0 // variant: shutdown level
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // two-wire bus pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // shutdown pin
   input  wire logic       shutdown_pin,
   // converter side
   output logic [9:0]      dac_code,
   output logic            dac_enable
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} vcdac_state_t;

   // pin synchronisers, first stage read only by the second
   // they reset to the idle levels of their pins: a bus at rest and the
   // shutdown input inactive, so no false start or shutdown follows reset
   logic [1:0] scl_s_q, sda_s_q, shd_s_q;
   logic       scl_p_q, sda_p_q;               // previous synced levels
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         shd_s_q <= {2{~SHDN_ACTIVE_HIGH}};
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         shd_s_q <= {shd_s_q[0], shutdown_pin};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end

   logic scl, sda, scl_rise, scl_fall, start_c, stop_c, shut;
   assign scl      = scl_s_q[1];
   assign sda      = sda_s_q[1];
   assign scl_rise = scl & ~scl_p_q;
   assign scl_fall = ~scl & scl_p_q;
   assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
   assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;
   assign shut     = (shd_s_q[1] == SHDN_ACTIVE_HIGH);

   // protocol state
   vcdac_state_t st_q, st_d;           // bus state
   logic [7:0]   sh_q, sh_d;           // shift register
   logic [3:0]   bit_q, bit_d;         // bits moved in the byte
   logic [1:0]   byte_q, byte_d;       // data byte index
   logic         rw_q, rw_d;           // read transaction
   logic         oe_q, oe_d;           // drive sda low
   logic [9:0]   code_q, code_d;       // input register
   logic [7:0]   hi_q, hi_d;           // first write byte held
   logic [1:0]   slew_q, slew_d;       // selected slew mode
   logic         valid_q, valid_d;     // a valid write has landed
   logic         rdone_q, rdone_d;     // a read byte went out

   // next protocol values
   // start and stop are checked ahead of the bit timing: the master may
   // abandon a transfer at any bit, and the state must follow at once
   // a read clears the input register only once a whole byte went out,
   // so an aborted address phase leaves the code untouched
   always_comb begin
      st_d = st_q; sh_d = sh_q; bit_d = bit_q; byte_d = byte_q; rw_d = rw_q;
      oe_d = oe_q; code_d = code_q; hi_d = hi_q; slew_d = slew_q;
      valid_d = valid_q; rdone_d = rdone_q;
      if (start_c) begin // start or repeated start
         if (rw_q && rdone_q) begin
            code_d = vcdac_pkg::CODE_RST;
         end
         st_d = ST_ADDR; bit_d = 4'h0; oe_d = 1'b0; rdone_d = 1'b0;
      end else if (stop_c) begin // transaction ends
         if (rw_q && rdone_q) begin
            code_d = vcdac_pkg::CODE_RST;
         end
         st_d = ST_IDLE; oe_d = 1'b0; rdone_d = 1'b0; rw_d = 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_WR: begin // shift in on rising edge
               if (scl_rise) begin
                  sh_d  = {sh_q[6:0], sda};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  bit_d = 4'h0;
                  if (st_q == ST_ADDR) begin
                     if (sh_q[7:1] == vcdac_pkg::SLAVE_ADDR) begin
                        oe_d = 1'b1; rw_d = sh_q[0]; byte_d = 2'h0; st_d = ST_AACK;
                     end else begin
                        st_d = ST_IDLE;
                     end
                  end else begin
                     oe_d = 1'b1; st_d = ST_WACK;
                     if (byte_q == 2'h0) begin // first byte: slew mode and top code bits
                        hi_d = sh_q;
                     end else if (byte_q == 2'h1) begin // second byte completes the code
                        code_d  = {hi_q[1:0], sh_q};
                        slew_d  = hi_q[5:4];
                        valid_d = 1'b1;
                     end
                     if (byte_q != 2'h3) begin // later bytes are acked and dropped, never wrap
                        byte_d = byte_q + 2'h1;
                     end
                  end
               end
            end
            ST_AACK, ST_WACK: begin // after the ack clock: release for a write, send the first read bit for a read
               if (scl_fall) begin
                  if (rw_q) begin
                     // read bytes use the write layout, mode beside the top code bits
                     sh_d = (byte_q == 2'h0) ? {2'h0, slew_q, 2'h0, code_q[9:8]} : code_q[7:0];
                     oe_d = ~sh_d[7]; // first bit goes out at once, pulled low for a zero
                     st_d = ST_RD;
                  end else begin
                     oe_d = 1'b0; st_d = ST_WR;
                  end
               end
            end
            ST_RD: begin // shift out on falling edge
               if (scl_fall) begin
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     oe_d = 1'b0; bit_d = 4'h0; st_d = ST_RACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            ST_RACK: begin // master ack or nack
               if (scl_rise) begin
                  rdone_d = 1'b1;
                  byte_d  = byte_q + 2'h1;
                  st_d    = sda ? ST_IDLE : ST_AACK;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // protocol registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE; sh_q <= 8'h00; bit_q <= 4'h0; byte_q <= 2'h0; rw_q <= 1'b0;
         oe_q <= 1'b0; code_q <= vcdac_pkg::CODE_RST; hi_q <= 8'h00;
         slew_q <= vcdac_pkg::SLEW_RST; valid_q <= 1'b0; rdone_q <= 1'b0;
      end else begin
         st_q <= st_d; sh_q <= sh_d; bit_q <= bit_d; byte_q <= byte_d; rw_q <= rw_d;
         oe_q <= oe_d; code_q <= code_d; hi_q <= hi_d;
         slew_q <= slew_d; valid_q <= valid_d; rdone_q <= rdone_d;
      end
   end

   // open-drain: only ever pulls low
   // the enable follows the synced pin, so it lags the pin by two clocks
   assign sda_out    = 1'b0;
   assign sda_oe     = oe_q;
   assign dac_enable = ~shut;

   // output shaper
   vcdac_slew #(.W(vcdac_pkg::CODE_W)) u_slew (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .target     (code_q),
      .mode       (slew_q),
      .force_zero (shut | ~valid_q),
      .drive_code (dac_code)
   );

   // assertions, each named after the rule it guards
   zero_before_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !valid_q |-> dac_code == 10'h000)
      else $error("output not zero before first write");
   shut_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      shut |-> !dac_enable ##1 dac_code == 10'h000)
      else $error("drive not off in shutdown");
   read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (stop_c && rw_q && rdone_q) |=> code_q == 10'h000)
      else $error("read did not clear");
   addr_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_ADDR && st_d == ST_AACK) |-> sh_q[7:1] == 7'h18)
      else $error("ack to wrong address");
   addr_other_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_ADDR && scl_fall && bit_q == 4'h8 && sh_q[7:1] != 7'h18) |=> (!sda_oe && st_q == ST_IDLE))
      else $error("foreign address not ignored");
   write_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_WR && st_d == ST_WACK && byte_q == 2'h1) |=> (valid_q && code_q == {hi_q[1:0], $past(sh_q)}))
      else $error("write not loaded");
   code_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_IDLE && !start_c && !stop_c) |=> $stable(code_q))
      else $error("code changed idle");
   direct_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (slew_q == 2'h0 && valid_q && !shut) [*2] |=> dac_code == $past(code_q))
      else $error("no direct follow");
   ack_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_AACK && scl_fall && !rw_q) |=> !sda_oe)
      else $error("ack held too long");
   rd_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_RD && scl_fall && bit_q == 4'h7) |=> !sda_oe)
      else $error("data held into master ack");
   rd_layout_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st_q == ST_AACK && scl_fall && rw_q && byte_q == 2'h0)
      |=> (st_q == ST_RD && sh_q == {2'h0, $past(slew_q), 2'h0, $past(code_q[9:8])} && sda_oe == ~sh_q[7]))
      else $error("read byte layout wrong");
   // covers for the main transfers and shutdown
   wr_cov: cover property (@(posedge sys_clk) st_q == ST_WACK && valid_q);
   rd_cov: cover property (@(posedge sys_clk) st_q == ST_RACK);
   shut_cov: cover property (@(posedge sys_clk) shut && valid_q);
   rclr_cov: cover property (@(posedge sys_clk) stop_c && rw_q && rdone_q);
endmodule // vcdac_top

// *** testbench/vcdac_i2c_master.sv ***
// two-wire bus master model that drives the device pins
`timescale 1ns/1ps
module vcdac_i2c_master (
   // clock
   input  wire logic sys_clk,
   // bus pins
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   localparam int Q = (vcdac_pkg::SCL_MIN_CYC + 3) / 4; // quarter bit, rounded up to stay at or under 400 kHz
   // idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // one bit: data changes only while clock low
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      wt(Q);
      scl = 1'b1;
      wt(Q);
      r = sda;
      wt(Q);
      scl = 1'b0;
      wt(Q);
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic byte_io(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ab, r);
      ok = !r;
   endtask
   // whole transfer: start, address, two bytes if acked, stop
   task automatic txn(input logic [7:0] ab, input logic [15:0] wd, output logic [15:0] rd, output logic ok);
      logic [7:0] tx;
      logic       k;
      rd = 16'h0000;
      sda_low = 1'b1;
      wt(Q);
      scl = 1'b0;
      wt(Q);
      byte_io(ab, 1'b1, tx, ok);
      if (ok) begin
         byte_io(ab[0] ? 8'hff : wd[15:8], !ab[0], rd[15:8], k);
         byte_io(ab[0] ? 8'hff : wd[7:0], 1'b1, rd[7:0], k);
      end
      sda_low = 1'b1;
      wt(Q);
      scl = 1'b1;
      wt(Q);
      sda_low = 1'b0;
      wt(2 * Q);
   endtask
endmodule // vcdac_i2c_master

// *** testbench/vcdac_top_bench.sv ***
// self-checking bench of the converter controller with a bus master model
`timescale 1ns/1ps
module vcdac_top_bench;
   logic        sys_clk;      // system clock
   logic        rst_b;        // reset, active low
   logic        shutdown_pin; // shutdown input
   logic        scl;          // bus clock
   logic        sda_low;      // master pulls data low
   logic        sda_oe;       // device pulls data low
   logic        sda_out;      // device data level while driving
   logic        sda;          // data line with pull-up
   logic [9:0]  dac_code;     // converter code
   logic        dac_enable;   // converter powered
   logic [15:0] exp_q[$];     // expected results, oldest first
   logic [15:0] got;          // result seen
   event        seen;         // a result is ready
   int          error_cnt = 0;
   int          tests_run = 0;
   int          cyc = 0;      // cycles run
   assign sda = !sda_low && !(sda_oe && !sda_out);
   vcdac_top #(.SHDN_ACTIVE_HIGH(1'b0)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .shutdown_pin(shutdown_pin), .dac_code(dac_code), .dac_enable(dac_enable));
   vcdac_i2c_master u_master (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
      tests_run++;
      if (seen_v !== exp_v) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   // monitor pairs each result with the oldest note
   always @(seen) check(got, exp_q.pop_front());
   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         final_report();
      end
   end
   // note an expectation and hand the result on
   task automatic note(input logic [15:0] g, input logic [15:0] e);
      exp_q.push_back(e);
      got = g;
      ->seen;
      @(negedge sys_clk);
   endtask
   // wait bounded for the output code
   task automatic expect_code(input logic [9:0] v, input int n);
      for (int i = 0; i < n && dac_code !== v; i++) @(negedge sys_clk);
      note({6'h00, dac_code}, {6'h00, v});
   endtask
   initial begin
      logic [15:0] rd;
      logic        ok;
      logic [9:0]  code;
      logic [1:0]  md;
      rst_b = 1'b0;
      shutdown_pin = 1'b1;
      void'($urandom(32'h3719));
      code = 10'($urandom_range(900, 100));
      repeat (6) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      expect_code(10'h000, 0);
      note({15'h0, dac_enable}, 16'h0001);
      u_master.txn({7'h19, 1'b0}, {6'h00, code}, rd, ok);
      note({15'h0, ok}, 16'h0000);
      expect_code(10'h000, 0);
      // modes 1, 2, 3, then direct; a ramp from zero in mode 1 takes four cycles a step
      for (int m = 1; m <= 4; m++) begin
         md = 2'(m);
         code = code + 10'h00c;
         u_master.txn({vcdac_pkg::SLAVE_ADDR, 1'b0}, {2'h0, md, 2'h0, code}, rd, ok);
         note({15'h0, ok}, 16'h0001);
         if (md == 2'h3) begin
            repeat (300) @(negedge sys_clk);
            note({15'h0, dac_code !== code}, 16'h0001);
         end
         expect_code(code, (md == 2'h0) ? 10 : 4200);
      end
      u_master.txn({vcdac_pkg::SLAVE_ADDR, 1'b1}, 16'h0000, rd, ok);
      note(rd, {6'h00, code});
      expect_code(10'h000, 20);
      u_master.txn({vcdac_pkg::SLAVE_ADDR, 1'b1}, 16'h0000, rd, ok);
      note(rd, 16'h0000);
      // rewrite a code in direct mode, then shut down and wake up
      u_master.txn({vcdac_pkg::SLAVE_ADDR, 1'b0}, {6'h00, code}, rd, ok);
      note({15'h0, ok}, 16'h0001);
      expect_code(code, 10);
      shutdown_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
      note({15'h0, dac_enable}, 16'h0000);
      note({6'h00, dac_code}, 16'h0000);
      shutdown_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      note({15'h0, dac_enable}, 16'h0001);
      expect_code(code, 10);
      final_report();
   end
endmodule // vcdac_top_bench
